//--- rtl/msa_core.sv
// memory space access: program counter, config copy, data space decode
// assumes the cpu address generation units drive requests on i_sys_clk
`timescale 1ns/10ps

module msa_core
  import msa_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // program counter control
  input  wire msa_pc_op_e  i_pc_op,
  input  wire logic [23:0] i_pc_load,
  input  wire logic [23:0] i_cfg_top_addr,
  // program memory port
  input  wire logic [23:0] i_prog_rdata,
  // read path from address generation unit
  input  wire msa_acc_s    i_rd,
  input  wire logic [15:0] i_rd_reg_old,
  input  wire msa_ext_e    i_rd_ext,
  input  wire logic [15:0] i_sfr_rdata,
  input  wire logic        i_sfr_hit,
  // write path from address generation unit
  input  wire msa_acc_s    i_wr,
  input  wire logic [15:0] i_wr_data,
  // program side outputs
  output logic [23:0]      o_prog_addr,
  output logic [23:0]      o_program_counter,
  output logic [23:0]      o_cfg_word0,
  output logic [23:0]      o_cfg_word1,
  output logic [23:0]      o_cfg_word2,
  output logic             o_cfg_ready,
  output logic [1:0]       o_vec_region,
  // read results
  output logic [15:0]      o_rd_data,
  output logic [15:0]      o_rd_reg_new,
  output logic             o_rd_valid,
  output logic             o_rd_psv,
  output logic [15:0]      o_rd_ptr_next,
  // write results
  output logic [1:0]       o_sfr_we,
  output logic [15:0]      o_wr_ptr_next,
  // trap
  output logic             o_addr_err
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // resolves near-form direct addresses to a full byte address
  function automatic logic [15:0] eff_addr(input msa_acc_s a);
    if (a.direct && a.near_form) begin
      eff_addr = {3'h0, a.effective_byte_address[NEAR_AW-1:0]};
    end else begin
      eff_addr = a.effective_byte_address;
    end
  endfunction

  function automatic logic misaligned(input msa_acc_s a);
    logic [15:0] ea;
    ea = eff_addr(a);
    misaligned = a.valid && !a.byte_op && ea[0];
  endfunction

  function automatic logic [15:0] ptr_step(input msa_acc_s a);
    ptr_step = a.effective_byte_address
             + (a.byte_op ? BYTE_STEP : WORD_STEP);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [23:0] pc;
    logic [23:0] paddr;
    msa_cfg_st_e cst;
    logic [1:0]  cidx;
    logic [23:0] cfg0;
    logic [23:0] cfg1;
    logic [23:0] cfg2;
    logic        cready;
    logic [1:0]  vreg;
    logic [15:0] rdata;
    logic [15:0] rnew;
    logic        rvalid;
    logic        rpsv;
    logic [15:0] rptr;
    logic [1:0]  we;
    logic [15:0] wptr;
    logic        aerr;
  } msa_state_s;

  msa_state_s st_reg;
  msa_state_s st_next;

  // data array: two byte-wide halves, shared word decode, own write lines
  logic [7:0]  ram_lo [RAM_WORDS];
  logic [7:0]  ram_hi [RAM_WORDS];
  logic [15:0] ram_word;
  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic        wr_ok;
  logic        wr_ram;
  logic [7:0]  rd_byte;
  logic [15:0] rd_raw;

  assign rd_ea  = eff_addr(i_rd);
  assign wr_ea  = eff_addr(i_wr);
  // misaligned write still runs the instruction, but no lane is strobed
  assign wr_ok  = i_wr.valid && !misaligned(i_wr);
  assign wr_ram = wr_ok && !wr_ea[PSV_BIT]
                && (wr_ea <= RAM_LAST) && (wr_ea > SFR_LAST);
  assign ram_word = {ram_hi[rd_ea[13:1]], ram_lo[rd_ea[13:1]]};

  always_ff @(posedge i_sys_clk) begin
    if (wr_ram && (!i_wr.byte_op || !wr_ea[0])) begin
      ram_lo[wr_ea[13:1]] <= i_wr.byte_op ? i_wr_data[7:0]
                                          : i_wr_data[7:0];
    end
    if (wr_ram && (!i_wr.byte_op || wr_ea[0])) begin
      ram_hi[wr_ea[13:1]] <= i_wr.byte_op ? i_wr_data[7:0]
                                          : i_wr_data[15:8];
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // program counter, always on the lower word
    unique case (i_pc_op)
      MSA_PC_INC:  st_next.pc = st_reg.pc + PC_STEP;
      MSA_PC_DEC:  st_next.pc = st_reg.pc - PC_STEP;
      MSA_PC_LOAD: st_next.pc = {i_pc_load[23:1], 1'b0};
      MSA_PC_HOLD: st_next.pc = st_reg.pc;
    endcase
    st_next.paddr = st_next.pc;
    // vector region flag: 1 primary, 2 alternate, 3 reset slot
    if (st_next.pc <= RESET_TGT_ADDR) begin
      st_next.vreg = 2'h3;
    end else if (st_next.pc >= IVT_PRI_FIRST
                 && st_next.pc <= IVT_PRI_LAST) begin
      st_next.vreg = 2'h1;
    end else if (st_next.pc >= IVT_ALT_FIRST
                 && st_next.pc <= IVT_ALT_LAST) begin
      st_next.vreg = 2'h2;
    end else begin
      st_next.vreg = 2'h0;
    end
    // config copy; core held at reset vector until done
    unique case (st_reg.cst)
      MSA_CFG_IDLE: begin
        st_next.cst   = MSA_CFG_REQ;
        st_next.cidx  = 2'h0;
        st_next.paddr = i_cfg_top_addr - 24'h000004;
        st_next.pc    = RESET_VEC_ADDR;
      end
      MSA_CFG_REQ: begin
        st_next.pc = RESET_VEC_ADDR;
        unique case (st_reg.cidx)
          2'h0:    st_next.cfg0 = {8'h00, i_prog_rdata[15:0]};
          2'h1:    st_next.cfg1 = {8'h00, i_prog_rdata[15:0]};
          default: st_next.cfg2 = {8'h00, i_prog_rdata[15:0]};
        endcase
        st_next.cidx  = st_reg.cidx + 2'h1;
        st_next.paddr = st_reg.paddr + PC_STEP;
        if (st_reg.cidx == CFG_WORDS - 2'h1) begin
          st_next.cst    = MSA_CFG_DONE;
          st_next.cready = 1'b1;
          st_next.paddr  = RESET_VEC_ADDR;
        end
      end
      MSA_CFG_DONE: st_next.cready = 1'b1;
      default:      st_next.cst = MSA_CFG_IDLE;
    endcase
    // read path
    st_next.rvalid = i_rd.valid;
    st_next.rpsv   = i_rd.valid && rd_ea[PSV_BIT];
    if (rd_ea[PSV_BIT] || rd_ea > RAM_LAST) begin
      rd_raw = 16'h0000;
    end else if (rd_ea <= SFR_LAST) begin
      rd_raw = i_sfr_hit ? i_sfr_rdata : 16'h0000;
    end else begin
      rd_raw = ram_word;
    end
    rd_byte = rd_ea[0] ? rd_raw[15:8] : rd_raw[7:0];
    st_next.rdata = i_rd.byte_op ? {8'h00, rd_byte} : rd_raw;
    if (i_rd.byte_op) begin
      unique case (i_rd_ext)
        MSA_EXT_SIGN: st_next.rnew = {{8{rd_byte[7]}}, rd_byte};
        MSA_EXT_ZERO: st_next.rnew = {8'h00, rd_byte};
        default:      st_next.rnew = {i_rd_reg_old[15:8], rd_byte};
      endcase
    end else begin
      st_next.rnew = rd_raw;
    end
    st_next.rptr = ptr_step(i_rd);
    // write path to register lanes
    st_next.we[0] = wr_ok && !wr_ea[PSV_BIT] && wr_ea <= SFR_LAST
                  && (!i_wr.byte_op || !wr_ea[0]);
    st_next.we[1] = wr_ok && !wr_ea[PSV_BIT] && wr_ea <= SFR_LAST
                  && (!i_wr.byte_op || wr_ea[0]);
    st_next.wptr  = ptr_step(i_wr);
    // read still completes; trap pulses with the access
    st_next.aerr  = misaligned(i_rd) || misaligned(i_wr);
    if (i_rst) begin
      st_next = '0;
      st_next.cst = MSA_CFG_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_prog_addr       = st_reg.paddr;
  assign o_program_counter = st_reg.pc;
  assign o_cfg_word0       = st_reg.cfg0;
  assign o_cfg_word1       = st_reg.cfg1;
  assign o_cfg_word2       = st_reg.cfg2;
  assign o_cfg_ready       = st_reg.cready;
  assign o_vec_region      = st_reg.vreg;
  assign o_rd_data         = st_reg.rdata;
  assign o_rd_reg_new      = st_reg.rnew;
  assign o_rd_valid        = st_reg.rvalid;
  assign o_rd_psv          = st_reg.rpsv;
  assign o_rd_ptr_next     = st_reg.rptr;
  assign o_sfr_we          = st_reg.we;
  assign o_wr_ptr_next     = st_reg.wptr;
  assign o_addr_err        = st_reg.aerr;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_bad_word_rd;
    i_rd.valid && !i_rd.byte_op && rd_ea[0];
  endsequence

  // idle step plus three word reads keep ready low
  sequence s_cfg_busy;
    !o_cfg_ready [*4];
  endsequence

  sequence s_cfg_at_vector;
    o_cfg_ready && o_program_counter == RESET_VEC_ADDR
    && o_prog_addr == RESET_VEC_ADDR;
  endsequence

  chk_pc_even_step: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    st_reg.cready && i_pc_op == MSA_PC_INC |=> o_program_counter ==
    $past(o_program_counter) + PC_STEP)
    else $error("pc step not two");
  chk_err_pulse_rd: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    s_bad_word_rd |=> o_addr_err && o_rd_valid)
    else $error("misaligned read not trapped");
  chk_err_one_cycle: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !(i_rd.valid || i_wr.valid) |=> !o_addr_err)
    else $error("address error without access");
  chk_wr_suppress: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr.valid && !i_wr.byte_op && wr_ea[0] |=> o_sfr_we == 2'h0)
    else $error("misaligned write not suppressed");
  chk_psv_zero: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_rd.valid && rd_ea[PSV_BIT] |=> o_rd_data == 16'h0000
    && o_rd_psv)
    else $error("window read not zero");
  chk_byte_lane: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_wr.valid && i_wr.byte_op && wr_ea <= SFR_LAST
    |=> o_sfr_we != 2'h3)
    else $error("byte write hit both lanes");
  chk_ptr_step: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_rd.byte_op |=> o_rd_ptr_next ==
    $past(i_rd.effective_byte_address) + BYTE_STEP)
    else $error("byte pointer step wrong");
  chk_cfg_copy: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    $fell(i_rst) |-> s_cfg_busy ##1 s_cfg_at_vector)
    else $error("config copy not finished at reset vector");

endmodule

//--- rtl/msa_pkg.sv
// package for the memory space access block: address map, widths, codes
// assumes a single 25 MHz system clock and a synchronous reset
package msa_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned PROG_AW   = 24;
  localparam int unsigned PROG_DW   = 24;
  localparam int unsigned DATA_AW   = 16;
  localparam int unsigned DATA_DW   = 16;
  localparam int unsigned NEAR_AW   = 13;
  localparam int unsigned RAM_WORDS = 8192;
  localparam int unsigned RAM_IW    = 13;

  // ----------------------------------------------------------------------
  // program space map
  // ----------------------------------------------------------------------
  localparam logic [23:0] RESET_VEC_ADDR  = 24'h000000;
  localparam logic [23:0] RESET_TGT_ADDR  = 24'h000002;
  localparam logic [23:0] IVT_PRI_FIRST   = 24'h000004;
  localparam logic [23:0] IVT_PRI_LAST    = 24'h0000ff;
  localparam logic [23:0] IVT_ALT_FIRST   = 24'h000100;
  localparam logic [23:0] IVT_ALT_LAST    = 24'h0001ff;
  localparam logic [23:0] PC_STEP         = 24'h000002;
  localparam logic [23:0] CFG_TOP_DEFAULT = 24'h02abfe;
  localparam logic [1:0]  CFG_WORDS       = 2'h3;

  // ----------------------------------------------------------------------
  // data space map
  // ----------------------------------------------------------------------
  localparam logic [15:0] SFR_LAST    = 16'h07ff;
  localparam logic [15:0] NEAR_LAST   = 16'h1fff;
  localparam logic [15:0] RAM_LAST    = 16'h3fff;
  localparam logic [15:0] BYTE_STEP   = 16'h0001;
  localparam logic [15:0] WORD_STEP   = 16'h0002;
  localparam int unsigned PSV_BIT     = 15;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MSA_PC_HOLD = 2'h0,
    MSA_PC_INC  = 2'h1,
    MSA_PC_DEC  = 2'h2,
    MSA_PC_LOAD = 2'h3
  } msa_pc_op_e;

  typedef enum logic [1:0] {
    MSA_CFG_IDLE = 2'h0,
    MSA_CFG_REQ  = 2'h1,
    MSA_CFG_DONE = 2'h3
  } msa_cfg_st_e;

  typedef enum logic [1:0] {
    MSA_EXT_NONE = 2'h0,
    MSA_EXT_SIGN = 2'h1,
    MSA_EXT_ZERO = 2'h2
  } msa_ext_e;

  typedef struct packed {
    logic        valid;
    logic        byte_op;
    logic        direct;
    logic        near_form;
    logic [15:0] effective_byte_address;
  } msa_acc_s;

endpackage

//--- verification/msa_mem_model.sv
// program memory and register file stand-in facing the access block
// assumes answers are combinational on the address, no wait states
`timescale 1ns/10ps
module msa_mem_model
  import msa_pkg::*;
(
  // requests seen from the block
  input  wire logic [23:0] i_prog_addr,
  input  wire msa_acc_s    i_rd,
  // answers
  output logic [23:0]      o_prog_rdata,
  output logic [15:0]      o_sfr_rdata,
  output logic             o_sfr_hit
);
  logic [15:0] wa;

  // top byte filled on purpose: the block has to drop it
  assign o_prog_rdata = {8'hee, i_prog_addr[15:0] ^ 16'ha5c3};
  assign wa           = {i_rd.effective_byte_address[15:1], 1'b0};
  // only the first 256 bytes hold registers; junk elsewhere, not zero
  assign o_sfr_hit    = i_rd.valid && (wa <= SFR_LAST) && (wa[10:8] == 3'h0);
  assign o_sfr_rdata  = o_sfr_hit ? (wa ^ 16'h3c00) : ~wa;
endmodule

//--- verification/testbench.sv
// self-checking bench for the memory space access block
// assumes registered outputs one edge after a request; drives on falling edge
`timescale 1ns/10ps
module testbench
  import msa_pkg::*;
  ;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  msa_pc_op_e  pc_op = MSA_PC_HOLD;
  logic [23:0] pc_ld = 24'h000000;
  logic [23:0] top = 24'h02abfe;
  msa_acc_s    rd = '0;
  msa_acc_s    wr = '0;
  logic [15:0] reg_old = 16'haaaa;
  msa_ext_e    ext = MSA_EXT_NONE;
  logic [15:0] wdata = 16'h0000;
  logic [23:0] prdata, paddr, pc, cw0, cw1, cw2;
  logic [15:0] sfr_d, rdata, rnew, rptr, wptr;
  logic        sfr_h, crdy, rvld, psv, err;
  logic [1:0]  vreg, swe;
  int          mismatches = 0;
  int          n_checks = 0;

  always #20 clk = ~clk;

  msa_core u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_pc_op(pc_op), .i_pc_load(pc_ld),
    .i_cfg_top_addr(top), .i_prog_rdata(prdata), .i_rd(rd),
    .i_rd_reg_old(reg_old), .i_rd_ext(ext), .i_sfr_rdata(sfr_d),
    .i_sfr_hit(sfr_h), .i_wr(wr), .i_wr_data(wdata), .o_prog_addr(paddr),
    .o_program_counter(pc), .o_cfg_word0(cw0), .o_cfg_word1(cw1),
    .o_cfg_word2(cw2), .o_cfg_ready(crdy), .o_vec_region(vreg),
    .o_rd_data(rdata), .o_rd_reg_new(rnew), .o_rd_valid(rvld),
    .o_rd_psv(psv), .o_rd_ptr_next(rptr), .o_sfr_we(swe),
    .o_wr_ptr_next(wptr), .o_addr_err(err)
  );

  msa_mem_model u_mem (
    .i_prog_addr(paddr), .i_rd(rd), .o_prog_rdata(prdata),
    .o_sfr_rdata(sfr_d), .o_sfr_hit(sfr_h)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic msa_acc_s acc(input logic [15:0] a, input logic b,
                                   input logic d = 1'b0,
                                   input logic n = 1'b0);
    return '{1'b1, b, d, n, a};
  endfunction

  // valid is left up so back-to-back calls never drop it in between
  task automatic go(input msa_acc_s r, input msa_acc_s w,
                    input logic [15:0] d = 16'h0000);
    rd = r;
    wr = w;
    wdata = d;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset(input logic [23:0] t);
    int k;
    top = t;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk(crdy, 1'b0);
    chk(err, 1'b0);
    rst = 1'b0;
    k = 0;
    while (crdy !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    chk(crdy, 1'b1);
    chk(cw0, {8'h00, (t[15:0] - 16'h0004) ^ 16'ha5c3});
    chk(cw1, {8'h00, (t[15:0] - 16'h0002) ^ 16'ha5c3});
    chk(cw2, {8'h00, t[15:0] ^ 16'ha5c3});
    chk(pc, RESET_VEC_ADDR);
    chk(paddr, RESET_VEC_ADDR);
    $display("reset test done, top %h", t);
  endtask

  task automatic t_pc();
    msa_pc_op_e  op[7] = '{MSA_PC_LOAD, MSA_PC_INC, MSA_PC_LOAD, MSA_PC_INC,
                           MSA_PC_LOAD, MSA_PC_INC, MSA_PC_DEC};
    logic [23:0] ld[7] = '{24'h000003, 24'h000000, 24'h0000ff, 24'h000000,
                           24'h0001ff, 24'h000000, 24'h000000};
    logic [23:0] ex[7] = '{24'h000002, 24'h000004, 24'h0000fe, 24'h000100,
                           24'h0001fe, 24'h000200, 24'h0001fe};
    logic [1:0]  rg[7] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
    for (int i = 0; i < 7; i++) begin
      pc_op = op[i];
      pc_ld = ld[i];
      @(posedge clk);
      @(negedge clk);
      pc_op = MSA_PC_HOLD;
      repeat (2) @(negedge clk);
      chk(pc, ex[i]);
      chk(vreg, rg[i]);
    end
    $display("program counter test done");
  endtask

  task automatic t_ram();
    go('0, acc(16'h0800, 1'b0), 16'hbeef);
    chk(wptr, 16'h0802);
    go('0, acc(16'h0801, 1'b1), 16'h3412);
    chk(wptr, 16'h0802);
    go('0, acc(16'h0802, 1'b1), 16'h0085);
    go(acc(16'h0800, 1'b0), '0);
    chk(rdata, 16'h12ef);
    chk(rvld, 1'b1);
    chk(rptr, 16'h0802);
    go(acc(16'h0801, 1'b1), '0);
    chk(rdata, 16'h0012);
    chk(rnew, 16'haa12);
    chk(rptr, 16'h0802);
    chk(err, 1'b0);
    ext = MSA_EXT_SIGN;
    go(acc(16'h0802, 1'b1), '0);
    chk(rnew, 16'hff85);
    ext = MSA_EXT_ZERO;
    go(acc(16'h0802, 1'b1), '0);
    chk(rnew, 16'h0085);
    ext = MSA_EXT_NONE;
    go('0, '0);
    chk(rvld, 1'b0);
    $display("byte lane test done");
  endtask

  task automatic t_misalign();
    go('0, acc(16'h0802, 1'b0), 16'h5a5a);
    chk(err, 1'b0);
    go('0, acc(16'h0803, 1'b0), 16'hffff);
    chk(err, 1'b1);
    go(acc(16'h0803, 1'b0), acc(16'h0003, 1'b0), 16'hffff);
    chk(err, 1'b1);
    chk(swe, 2'h0);
    chk(rvld, 1'b1);
    go('0, '0);
    chk(err, 1'b0);
    go(acc(16'h0802, 1'b0), '0);
    chk(rdata, 16'h5a5a);
    $display("misaligned access test done");
  endtask

  task automatic t_map();
    go('0, acc(16'h0004, 1'b1), 16'h0011);
    chk(swe, 2'h1);
    go('0, acc(16'h0005, 1'b1), 16'h0011);
    chk(swe, 2'h2);
    go('0, acc(16'h0006, 1'b0), 16'h1111);
    chk(swe, 2'h3);
    go(acc(16'h0002, 1'b0), acc(16'h0900, 1'b0), 16'h2222);
    chk(swe, 2'h0);
    chk(rdata, 16'h3c02);
    go(acc(16'h0003, 1'b1), '0);
    chk(rdata, 16'h003c);
    go(acc(16'h0402, 1'b0), '0);
    chk(rdata, 16'h0000);
    go(acc(16'h4000, 1'b0), '0);
    chk(rdata, 16'h0000);
    chk(psv, 1'b0);
    go(acc(16'h8000, 1'b0), '0);
    chk(psv, 1'b1);
    chk(rdata, 16'h0000);
    go(acc(16'he800, 1'b0, 1'b1, 1'b1), acc(16'h2000, 1'b0, 1'b1),
       16'h5678);
    chk(rdata, 16'h12ef);
    chk(psv, 1'b0);
    go(acc(16'h2000, 1'b0, 1'b1), '0);
    chk(rdata, 16'h5678);
    go('0, '0);
    $display("address map test done");
  endtask

  initial begin
    t_reset(24'h02abfe);
    t_pc();
    t_ram();
    t_misalign();
    t_map();
    t_reset(24'h0157fe);
    tally_and_finish();
  end

  // tests take about 60 cycles; 3000 can only mean a hang
  initial begin
    #(40 * 3000);
    mismatches++;
    tally_and_finish();
  end
endmodule
